// *** hw/scm_defs.svh ***
// Constants for the supercap monitor command port
// Assumes a 125 MHz clock and word-level command framing
`ifndef SCM_DEFS_SVH
`define SCM_DEFS_SVH
`define SCM_CLK_HZ 125000000
`define SCM_CKSUM_MS 45
`define SCM_UNSEAL_WAIT_S 4
`define SCM_RST_HOLD_MS 2
`define SCM_CMD_VENDOR 8'h00
`define SCM_CMD_TEMP 8'h08
`define SCM_CMD_VOLT 8'h09
`define SCM_CMD_CURR 8'h0a
`define SCM_SUB_ID 16'h0001
`define SCM_SUB_FW 16'h0002
`define SCM_SUB_HW 16'h0003
`define SCM_SUB_CKSUM 16'h0004
`define SCM_SUB_SEAL 16'h0020
`define SCM_SUB_LIFE 16'h0021
`define SCM_SUB_FLT_ON 16'h0030
`define SCM_SUB_FLT_OFF 16'h0031
`define SCM_SUB_CHA_ON 16'h0032
`define SCM_SUB_CHA_OFF 16'h0033
`define SCM_SUB_CHB_OFF 16'h0034
`define SCM_SUB_LL_ON 16'h0037
`define SCM_SUB_LL_OFF 16'h0038
`define SCM_SUB_CAL 16'h0040
`define SCM_SUB_RESET 16'h0041
`define SCM_LIFE_OFF 16'h0000
`define SCM_LIFE_ON 16'h0001
`define SCM_VOLT_MAX 16'h4e20
`define SCM_RST_SEALED 1'b1
`define SCM_RST_LIFE 1'b1
`define SCM_OS_SS 0
`define SCM_OS_CAL 1
`define SCM_OS_CKB 2
`define SCM_OS_LIFE 3
`define SCM_OS_LOCK 4
`define SCM_OS_DIS 5
`endif

// *** hw/scm_pkg.sv ***
// Types for the supercap monitor command port
// Assumes scm_defs.svh holds the numeric constants
package scm_pkg;
  typedef logic [15:0] scm_word_t;
  typedef enum logic [1:0] {
    SCM_ST_IDLE,
    SCM_ST_KEY2,
    SCM_ST_LIFE
  } scm_step_t;
endpackage

// *** hw/scm_timer.sv ***
// One-shot down counter with a done pulse in its last busy cycle
// Assumes count is at least one
module scm_timer #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic [W-1:0] count,
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt_q;

  initial begin
    if (W < 2) $error("scm_timer width too small");
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
    end else if (start && cnt_q == '0) begin
      cnt_q <= count;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign busy = (cnt_q != '0);
  assign done = (cnt_q == W'(1));
endmodule

// *** hw/scm_checksum.sv ***
// Byte sum over the whole nonvolatile store, one byte per cycle
// Assumes store_rdata follows store_addr by one clock
module scm_checksum #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  output logic [AW-1:0] store_addr,
  input wire logic [7:0] store_rdata,
  output logic busy,
  output logic [15:0] sum
);
  logic [AW-1:0] addr_q;
  logic run_q;
  logic take_q;
  logic [15:0] sum_q;

  initial begin
    if (DEPTH < 2 || DEPTH > (1 << AW)) $error("scm_checksum depth");
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      addr_q <= '0;
      run_q <= 1'b0;
    end else if (start && !busy) begin
      addr_q <= '0;
      run_q <= 1'b1;
    end else if (run_q) begin
      addr_q <= addr_q + AW'(1);
      run_q <= (addr_q != AW'(DEPTH - 1));
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      take_q <= 1'b0;
      sum_q <= '0;
    end else begin
      take_q <= run_q;
      if (start && !busy) begin
        sum_q <= '0;
      end else if (take_q) begin
        sum_q <= sum_q + {8'h00, store_rdata};
      end
    end
  end

  assign store_addr = addr_q;
  assign busy = run_q | take_q;
  assign sum = sum_q;
endmodule

// *** hw/scm_cmd_port.sv ***
// Command port of the supercap monitor: vendor word and read words
// Assumes an upstream bus slave hands over whole words on clk
// Behaviour
// RULE_01: Subcommand 1 returns the part identity word
// RULE_02: Subcommand 2 returns major, minor firmware version
// RULE_03: Subcommand 3 returns stored hardware version byte
// RULE_04: Unsealed subcommand 4 starts checksum, done 45ms
// RULE_05: Checksum completes; vendor reads wait meanwhile
// RULE_06: Unsealed subcommand 0x20 seals the device
// RULE_07: Subcommand 0x21 controls logging and balancing
// RULE_08: Value 0 disables both, 1 enables both; code keeps balance_en on while discharge_req is set
// RULE_09: Unsealed 0x30 raises fault, 0x31 lowers it
// RULE_10: Unsealed 0x32 raises charge level A, 0x33 lowers
// RULE_11: Unsealed 0x33 raises level B, 0x34 lowers
// RULE_12: Unsealed 0x37 raises learn load, 0x38 lowers
// RULE_13: Unsealed 0x40 enters calibration mode
// RULE_14: Unsealed 0x41 resets, holding clock line low
// RULE_15: After reset discharge stack if above target
// RULE_16: Sealed, key one then key two unseals
// RULE_17: Failed unseal locks out retries for 4 s
// RULE_18: Extended result read back from vendor word
// RULE_19: Word 8 returns selected temperature source
// RULE_20: Word 9 returns stack voltage up to 20000
// RULE_21: Word 0x0a returns signed stack current
// RULE_22: Current inside dead band reads as zero
// RULE_23: Commands not allowed in this state are ignored
`include "scm_defs.svh"
module scm_cmd_port
  import scm_pkg::*;
#(
  parameter logic [15:0] PART_ID = 16'h5a5a, // Arbitrary value
  parameter logic [7:0] FW_MAJOR = 8'h01,
  parameter logic [7:0] FW_MINOR = 8'h00,
  parameter logic [15:0] KEY1 = 16'h1234,
  parameter logic [15:0] KEY2 = 16'h5678,
  parameter int STORE_DEPTH = 256,
  parameter int STORE_AW = 8,
  parameter int CKSUM_CYC = `SCM_CKSUM_MS * (`SCM_CLK_HZ / 1000),
  parameter int UNSEAL_WAIT_CYC = `SCM_UNSEAL_WAIT_S * `SCM_CLK_HZ,
  parameter int RST_HOLD_CYC = `SCM_RST_HOLD_MS * (`SCM_CLK_HZ / 1000)
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic rd_valid,
  output logic [15:0] rd_data,
  output logic scl_low_oe,
  output logic [STORE_AW-1:0] store_addr,
  input wire logic [7:0] store_rdata,
  input wire logic [7:0] hw_version_byte,
  input wire logic [15:0] temp_src0,
  input wire logic [15:0] temp_src1,
  input wire logic [15:0] temp_src2,
  input wire logic [15:0] temp_src3,
  input wire logic temp_source_sel_hi,
  input wire logic temp_source_sel_lo,
  input wire logic [15:0] stack_mv,
  input wire logic [15:0] stack_ma,
  input wire logic [15:0] deadband_ma,
  input wire logic [15:0] target_charge_voltage,
  output logic fault_out,
  output logic charge_level_out_a,
  output logic charge_level_out_b,
  output logic learn_load_enable_out,
  output logic calib_mode,
  output logic lifetime_log_en,
  output logic balance_en,
  output logic discharge_req,
  output logic [15:0] operation_state_word
);
  scm_step_t step_q;
  logic sealed_q, fault_q, cha_q, chb_q, ll_q, cal_q, life_q;
  logic after_rst_q, dis_q, pend_q, rd_valid_q;
  logic [15:0] last_sub_q, rd_data_q, os_q;
  logic hold_busy, hold_done, lock_busy, cks_busy, soft_rst;
  logic acc_wr, acc_ok, rd_req, unseal_fail;
  logic [15:0] cks_sum, rd_mux, temp_sel;
  logic [7:0] rd_code;
  logic [16:0] cur_mag;

  initial begin
    if (STORE_DEPTH + 2 > CKSUM_CYC) $error("checksum too slow");
    if (RST_HOLD_CYC < 1 || UNSEAL_WAIT_CYC < 1) $error("bad timing");
  end

  assign soft_rst = hold_done;
  assign acc_wr = cmd_valid && cmd_write && !hold_busy &&
                  cmd_code == `SCM_CMD_VENDOR;
  assign acc_ok = acc_wr && step_q == SCM_ST_IDLE && !sealed_q; // RULE_23
  assign rd_req = cmd_valid && !cmd_write && !hold_busy;
  assign unseal_fail = acc_wr && step_q == SCM_ST_KEY2 &&
                       cmd_wdata != KEY2;

  scm_timer #(.W(32)) u_hold (
    .clk(clk),
    .srst(srst),
    .start(acc_ok && cmd_wdata == `SCM_SUB_RESET), // RULE_14
    .count(32'(RST_HOLD_CYC)),
    .busy(hold_busy),
    .done(hold_done)
  );

  scm_timer #(.W(32)) u_lock (
    .clk(clk),
    .srst(srst),
    .start(unseal_fail), // RULE_17
    .count(32'(UNSEAL_WAIT_CYC)),
    .busy(lock_busy),
    .done()
  );

  scm_checksum #(.DEPTH(STORE_DEPTH), .AW(STORE_AW)) u_cks (
    .clk(clk),
    .srst(srst || soft_rst),
    .start(acc_ok && cmd_wdata == `SCM_SUB_CKSUM), // RULE_04
    .store_addr(store_addr),
    .store_rdata(store_rdata),
    .busy(cks_busy),
    .sum(cks_sum)
  );

  // Security state and two-step sequences
  always_ff @(posedge clk) begin
    if (srst || soft_rst) begin
      sealed_q <= `SCM_RST_SEALED;
      step_q <= SCM_ST_IDLE;
      life_q <= `SCM_RST_LIFE;
    end else if (acc_wr) begin
      unique case (step_q)
        SCM_ST_KEY2: begin
          if (cmd_wdata == KEY2) begin
            sealed_q <= 1'b0; // RULE_16
          end
          step_q <= SCM_ST_IDLE;
        end
        SCM_ST_LIFE: begin
          if (cmd_wdata == `SCM_LIFE_OFF) begin
            life_q <= 1'b0; // RULE_08
          end else if (cmd_wdata == `SCM_LIFE_ON) begin
            life_q <= 1'b1; // RULE_08
          end
          step_q <= SCM_ST_IDLE;
        end
        SCM_ST_IDLE: begin
          if (cmd_wdata == `SCM_SUB_LIFE) begin
            step_q <= SCM_ST_LIFE; // RULE_07
          end else if (sealed_q && !lock_busy && cmd_wdata == KEY1) begin
            step_q <= SCM_ST_KEY2; // RULE_16
          end else if (!sealed_q && cmd_wdata == `SCM_SUB_SEAL) begin
            sealed_q <= 1'b1; // RULE_06
          end
        end
        default: step_q <= SCM_ST_IDLE;
      endcase
    end
  end

  // Last subcommand, read back through the vendor word
  always_ff @(posedge clk) begin
    if (srst || soft_rst) begin
      last_sub_q <= '0;
    end else if (acc_wr && step_q == SCM_ST_IDLE) begin
      last_sub_q <= cmd_wdata; // RULE_18
    end
  end

  // Directly driven outputs
  always_ff @(posedge clk) begin
    if (srst || soft_rst) begin
      fault_q <= 1'b0;
      cha_q <= 1'b0;
      chb_q <= 1'b0;
      ll_q <= 1'b0;
      cal_q <= 1'b0;
    end else if (acc_ok) begin
      unique case (cmd_wdata)
        `SCM_SUB_FLT_ON: fault_q <= 1'b1; // RULE_09
        `SCM_SUB_FLT_OFF: fault_q <= 1'b0; // RULE_09
        `SCM_SUB_CHA_ON: cha_q <= 1'b1; // RULE_10
        `SCM_SUB_CHA_OFF: begin
          cha_q <= 1'b0; // RULE_10
          chb_q <= 1'b1; // RULE_11
        end
        `SCM_SUB_CHB_OFF: chb_q <= 1'b0; // RULE_11
        `SCM_SUB_LL_ON: ll_q <= 1'b1; // RULE_12
        `SCM_SUB_LL_OFF: ll_q <= 1'b0; // RULE_12
        `SCM_SUB_CAL: cal_q <= 1'b1; // RULE_13
        default: ;
      endcase
    end
  end

  // Discharge through balancing after any reset while above target
  always_ff @(posedge clk) begin
    if (srst || soft_rst) begin
      after_rst_q <= 1'b1;
      dis_q <= 1'b0;
    end else begin
      dis_q <= after_rst_q && target_charge_voltage < stack_mv; // RULE_15
      if (target_charge_voltage >= stack_mv) begin
        after_rst_q <= 1'b0;
      end
    end
  end

  // Read data selection
  always_comb begin
    unique case ({temp_source_sel_hi, temp_source_sel_lo})
      2'b00: temp_sel = temp_src0; // RULE_19
      2'b01: temp_sel = temp_src1;
      2'b10: temp_sel = temp_src2;
      2'b11: temp_sel = temp_src3;
    endcase
  end

  assign cur_mag = stack_ma[15] ? 17'(-{1'b1, stack_ma})
                                : {1'b0, stack_ma};
  assign rd_code = pend_q ? `SCM_CMD_VENDOR : cmd_code;

  always_comb begin
    rd_mux = '0;
    unique case (rd_code)
      `SCM_CMD_TEMP: rd_mux = temp_sel; // RULE_19
      `SCM_CMD_VOLT: begin
        rd_mux = (stack_mv > `SCM_VOLT_MAX) ? `SCM_VOLT_MAX
                                           : stack_mv; // RULE_20
      end
      `SCM_CMD_CURR: begin
        if (cur_mag > {1'b0, deadband_ma}) begin
          rd_mux = stack_ma; // RULE_21
        end else begin
          rd_mux = '0; // RULE_22
        end
      end
      `SCM_CMD_VENDOR: begin
        unique case (last_sub_q)
          `SCM_SUB_ID: rd_mux = PART_ID; // RULE_01
          `SCM_SUB_FW: rd_mux = {FW_MAJOR, FW_MINOR}; // RULE_02
          `SCM_SUB_HW: rd_mux = {8'h00, hw_version_byte}; // RULE_03
          `SCM_SUB_CKSUM: rd_mux = cks_sum; // RULE_04
          `SCM_SUB_LIFE: rd_mux = {15'h0000, life_q}; // RULE_07
          default: rd_mux = os_q;
        endcase
      end
      default: rd_mux = '0;
    endcase
  end

  // Read answer; vendor reads wait for a running checksum
  always_ff @(posedge clk) begin
    if (srst || soft_rst) begin
      pend_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
    end else begin
      rd_valid_q <= 1'b0;
      if (pend_q) begin
        if (!cks_busy) begin
          pend_q <= 1'b0; // RULE_05
          rd_valid_q <= 1'b1;
          rd_data_q <= rd_mux;
        end
      end else if (rd_req) begin
        if (cmd_code == `SCM_CMD_VENDOR && cks_busy) begin
          pend_q <= 1'b1; // RULE_05
        end else begin
          rd_valid_q <= 1'b1;
          rd_data_q <= rd_mux;
        end
      end
    end
  end

  // Operation state word
  always_ff @(posedge clk) begin
    if (srst) begin
      os_q <= '0;
    end else begin
      os_q <= '0;
      os_q[`SCM_OS_SS] <= sealed_q;
      os_q[`SCM_OS_CAL] <= cal_q;
      os_q[`SCM_OS_CKB] <= cks_busy;
      os_q[`SCM_OS_LIFE] <= life_q;
      os_q[`SCM_OS_LOCK] <= lock_busy;
      os_q[`SCM_OS_DIS] <= dis_q;
    end
  end

  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
  assign scl_low_oe = hold_busy; // RULE_14
  assign fault_out = fault_q;
  assign charge_level_out_a = cha_q;
  assign charge_level_out_b = chb_q;
  assign learn_load_enable_out = ll_q;
  assign calib_mode = cal_q;
  assign lifetime_log_en = life_q; // RULE_07
  assign balance_en = life_q || dis_q; // RULE_15
  assign discharge_req = dis_q;
  assign operation_state_word = os_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  fault_set_a: assert property ( // RULE_09
    acc_ok && cmd_wdata == `SCM_SUB_FLT_ON |=> fault_out)
    else $error("fault not raised");
  sealed_ignore_a: assert property ( // RULE_23
    acc_wr && sealed_q && step_q == SCM_ST_IDLE |=> $stable(fault_out)
      && $stable(charge_level_out_a) && $stable(calib_mode))
    else $error("sealed command took effect");
  level_b_a: assert property ( // RULE_11
    acc_ok && cmd_wdata == `SCM_SUB_CHA_OFF
      |=> charge_level_out_b && !charge_level_out_a)
    else $error("level swap wrong");
  seal_cmd_a: assert property ( // RULE_06
    acc_ok && cmd_wdata == `SCM_SUB_SEAL |=> sealed_q
      ##1 operation_state_word[`SCM_OS_SS])
    else $error("seal flag not set");
  unseal_seq_a: assert property ( // RULE_16
    acc_wr && step_q == SCM_ST_KEY2 && cmd_wdata == KEY2 |=> !sealed_q)
    else $error("unseal failed");
  lockout_a: assert property ( // RULE_17
    unseal_fail |=> lock_busy [*8])
    else $error("no retry lockout");
  reset_hold_a: assert property ( // RULE_14
    acc_ok && cmd_wdata == `SCM_SUB_RESET |=> scl_low_oe [*8])
    else $error("clock line not held");
  deadband_a: assert property ( // RULE_22
    rd_req && !pend_q && cmd_code == `SCM_CMD_CURR
      && cur_mag <= {1'b0, deadband_ma} |=> rd_valid && rd_data == 16'h0000)
    else $error("dead band not zero");
  volt_max_a: assert property ( // RULE_20
    rd_valid && $past(rd_code) == `SCM_CMD_VOLT
      |-> rd_data <= `SCM_VOLT_MAX)
    else $error("voltage over range");
  cksum_start_a: assert property ( // RULE_04
    acc_ok && cmd_wdata == `SCM_SUB_CKSUM && !cks_busy
      |=> cks_busy ##[1:300] !cks_busy)
    else $error("checksum not started");
endmodule

// *** verification/scm_store_model.sv ***
// Nonvolatile store model answering byte reads of the command port
// Assumes the port presents one registered byte address per clock
module scm_store_model #(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic [AW-1:0] store_addr,
  output logic [7:0] store_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [DEPTH];
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = 8'(8'h11 * (i + 1));
    end
  end
  // Data follows the address by one clock
  always_ff @(posedge clk) begin
    store_rdata <= mem[store_addr];
  end
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the supercap monitor command port
// Assumes shortened timing parameters and the store model on the byte port
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int UW = 50;
  localparam int RH = 20;
  localparam logic [15:0] K1 = 16'h1234;
  localparam logic [15:0] K2 = 16'h5678;
  // Arbitrary identity value
  localparam logic [15:0] PID = 16'h5a5a;
  localparam logic [15:0] SC [7] = '{16'h0030, 16'h0032, 16'h0033,
    16'h0034, 16'h0037, 16'h0038, 16'h0031};
  localparam logic [15:0] EX [7] = '{16'h0008, 16'h000c, 16'h000a,
    16'h0008, 16'h0009, 16'h0008, 16'h0000};
  localparam logic [7:0] MC [8] = '{8'h09, 8'h09, 8'h09, 8'h0a, 8'h0a,
    8'h0a, 8'h0a, 8'h0a};
  localparam logic [15:0] MD [8] = '{16'h1234, 16'h4e21, 16'hffff,
    16'hfff6, 16'h000a, 16'h000b, 16'hfff5, 16'h8000};
  localparam logic [15:0] ME [8] = '{16'h1234, 16'h4e20, 16'h4e20,
    16'h0000, 16'h0000, 16'h000b, 16'hfff5, 16'h8000};
  localparam logic [15:0] TV [4] = '{16'h0bb8, 16'h0c1c, 16'h0c80,
    16'h0ce4};
  logic clk = 1'b0;
  logic srst, cmd_valid, cmd_write, rd_valid, scl_low_oe;
  logic [7:0] cmd_code, hw_version_byte, store_rdata;
  logic [15:0] cmd_wdata, stack_mv, stack_ma, deadband_ma, rd_data;
  logic [15:0] target_charge_voltage, operation_state_word;
  logic temp_source_sel_hi, temp_source_sel_lo, fault_out, calib_mode;
  logic charge_level_out_a, charge_level_out_b, learn_load_enable_out;
  logic lifetime_log_en, balance_en, discharge_req;
  logic [2:0] store_addr;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  wire [15:0] pins = {12'h0, fault_out, charge_level_out_a,
    charge_level_out_b, learn_load_enable_out};
  wire [15:0] life2 = {14'h0, lifetime_log_en, balance_en};
  always #4 clk = ~clk;

  scm_cmd_port #(.PART_ID(PID), .FW_MAJOR(8'h02), .FW_MINOR(8'h35),
    .KEY1(K1), .KEY2(K2), .STORE_DEPTH(8), .STORE_AW(3), .CKSUM_CYC(16),
    .UNSEAL_WAIT_CYC(UW), .RST_HOLD_CYC(RH)) scm_cmd_port_i (
    .clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_valid(rd_valid),
    .rd_data(rd_data), .scl_low_oe(scl_low_oe), .store_addr(store_addr),
    .store_rdata(store_rdata), .hw_version_byte(hw_version_byte),
    .temp_src0(TV[0]), .temp_src1(TV[1]), .temp_src2(TV[2]),
    .temp_src3(TV[3]), .temp_source_sel_hi(temp_source_sel_hi),
    .temp_source_sel_lo(temp_source_sel_lo), .stack_mv(stack_mv),
    .stack_ma(stack_ma), .deadband_ma(deadband_ma),
    .target_charge_voltage(target_charge_voltage), .fault_out(fault_out),
    .charge_level_out_a(charge_level_out_a),
    .charge_level_out_b(charge_level_out_b),
    .learn_load_enable_out(learn_load_enable_out), .calib_mode(calib_mode),
    .lifetime_log_en(lifetime_log_en), .balance_en(balance_en),
    .discharge_req(discharge_req),
    .operation_state_word(operation_state_word));

  scm_store_model #(.DEPTH(8), .AW(3)) scm_store_model_i (
    .clk(clk), .store_addr(store_addr), .store_rdata(store_rdata));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= 1'b1;
    cmd_code <= code;
    cmd_wdata <= data;
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    int n;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= 1'b0;
    cmd_code <= code;
    @(posedge clk);
    cmd_valid <= 1'b0;
    n = 0;
    #1;
    while (rd_valid !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(16'(rd_valid), 16'h0001);
    chk(rd_data, exp);
  endtask

  task automatic settle;
    @(posedge clk);
    #1;
  endtask

  task automatic tend(input string s);
    $display("Test %s done", s);
  endtask

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      test_done;
    end
  end

  initial begin
    int n;
    srst <= 1'b1;
    cmd_valid <= 1'b0;
    cmd_write <= 1'b0;
    cmd_code <= 8'h00;
    cmd_wdata <= 16'h0000;
    hw_version_byte <= 8'ha7;
    {temp_source_sel_hi, temp_source_sel_lo} <= 2'h0;
    stack_mv <= 16'h1000;
    stack_ma <= 16'h0000;
    deadband_ma <= 16'h000a;
    target_charge_voltage <= 16'h4000;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    settle;
    chk(operation_state_word, 16'h0009);
    chk(life2, 16'h0003);
    rd(8'h00, 16'h0009);
    tend("reset");
    wr(8'h00, 16'h0030);
    settle;
    chk(pins, 16'h0000);
    wr(8'h00, 16'h0001);
    rd(8'h00, PID);
    wr(8'h00, 16'h0002);
    rd(8'h00, 16'h0235);
    wr(8'h00, 16'h0003);
    rd(8'h00, 16'h00a7);
    rd(8'h0b, 16'h0000);
    tend("identity");
    wr(8'h00, K1);
    wr(8'h00, 16'h9999);
    settle;
    chk(operation_state_word, 16'h0019);
    wr(8'h00, K1);
    wr(8'h00, K2);
    settle;
    chk(16'(operation_state_word[0]), 16'h0001);
    repeat (UW + 10) @(posedge clk);
    wr(8'h00, K1);
    wr(8'h00, K2);
    settle;
    chk(operation_state_word, 16'h0008);
    tend("unseal");
    for (int i = 0; i < 7; i++) begin
      wr(8'h00, SC[i]);
      settle;
      chk(pins, EX[i]);
    end
    for (int j = 0; j < 4; j++) begin
      wr(8'h00, 16'h0021);
      wr(8'h00, 16'(j % 2));
      settle;
      chk(life2, 16'(3 * (j % 2)));
    end
    rd(8'h00, 16'h0001);
    tend("outputs");
    wr(8'h00, 16'h0004);
    rd(8'h00, 16'h0264);
    tend("checksum");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {temp_source_sel_hi, temp_source_sel_lo} <= 2'(i);
      rd(8'h08, TV[i]);
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      if (MC[i] == 8'h09) stack_mv <= MD[i];
      else stack_ma <= MD[i];
      rd(MC[i], ME[i]);
    end
    @(posedge clk);
    deadband_ma <= 16'h0004;
    stack_ma <= 16'h0005;
    rd(8'h0a, 16'h0005);
    @(posedge clk);
    stack_ma <= 16'hfffc;
    rd(8'h0a, 16'h0000);
    tend("measure");
    wr(8'h00, 16'h0020);
    wr(8'h00, 16'h0040);
    settle;
    chk({15'h0, operation_state_word[0]}, 16'h0001);
    chk(16'(calib_mode), 16'h0000);
    wr(8'h00, K1);
    wr(8'h00, K2);
    wr(8'h00, 16'h0040);
    settle;
    chk(16'(calib_mode), 16'h0001);
    @(posedge clk);
    stack_mv <= 16'h4e20;
    wr(8'h00, 16'h0041);
    settle;
    chk(16'(scl_low_oe), 16'h0001);
    n = 0;
    while (scl_low_oe === 1'b1 && n < RH + 10) begin
      settle;
      n++;
    end
    chk(16'(scl_low_oe), 16'h0000);
    repeat (3) settle;
    chk(operation_state_word, 16'h0029);
    chk({14'h0, discharge_req, balance_en}, 16'h0003);
    @(posedge clk);
    target_charge_voltage <= 16'h5000;
    repeat (2) settle;
    chk(16'(discharge_req), 16'h0000);
    tend("reset command");
    test_done;
  end
endmodule
